// ==== lfr_pkg.sv ====
//------------------------------------------------------------------
// Purpose: Shared constants and types for the LED line fault registers
// Assumes: 32-bit Avalon-MM data, 48-bit registers split in two words
// Notes:   Upper word of each register holds bits 47..32
//------------------------------------------------------------------
package lfr_pkg;

    //--------------------------------------------------------------
    // Geometry
    //--------------------------------------------------------------
    localparam int LINE_W    = 6;   // Line number width
    localparam int NUM_LINES = 64;  // Scan lines covered
    localparam int LOW_LINES = 48;  // Lines in the low-line words
    localparam int HI_LINES  = 16;  // Lines in the high-line words
    localparam int REG_W     = 48;  // Documented register width
    localparam int BUS_W     = 32;  // Avalon data width
    localparam int ADDR_W    = 6;   // Byte address width
    localparam int UPPER_W   = REG_W - BUS_W;

    //--------------------------------------------------------------
    // Byte offsets; each register takes a low and a high word
    //--------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFF_SHORT_SEL  = 6'h00;
    localparam logic [ADDR_W-1:0] OFF_OPEN_SEL   = 6'h08;
    localparam logic [ADDR_W-1:0] OFF_OPEN_HIGH  = 6'h10;
    localparam logic [ADDR_W-1:0] OFF_OPEN_LOW   = 6'h18;
    localparam logic [ADDR_W-1:0] OFF_SHORT_HIGH = 6'h20;
    localparam logic [ADDR_W-1:0] OFF_SHORT_LOW  = 6'h28;
    localparam logic [ADDR_W-1:0] OFF_IRQ        = 6'h30;
    localparam int                PAIR_LSB       = 3;
    localparam int                HALF_BIT       = 2;

    //--------------------------------------------------------------
    // Reset values and interrupt layout
    //--------------------------------------------------------------
    localparam logic [LINE_W-1:0] SEL_RESET  = 6'h00;
    localparam int                IRQ_W      = 2;
    localparam int                IRQ_OPEN   = 0;
    localparam int                IRQ_SHORT  = 1;
    localparam logic [IRQ_W-1:0]  IRQ_RESET  = 2'h0;

    // One detection result for one scan line
    typedef struct packed {
        logic              valid;
        logic [LINE_W-1:0] line;
        logic              fault;
    } lfr_det_t;

endpackage

// ==== lfr_flag_bank.sv ====
//------------------------------------------------------------------
// Purpose: Per-line warning flags updated by detection results
// Assumes: Detection results arrive on clk, one line per cycle
// Notes:   Flags are not writable from the bus
//------------------------------------------------------------------
`timescale 1ns/1ps
module lfr_flag_bank
    import lfr_pkg::*;
#(
    parameter int NUM = NUM_LINES
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst_n,
    // Detection result
    input  wire lfr_det_t       det,
    // Flag state
    output logic [NUM-1:0]      flags_reg,
    output logic                rise
);

    //--------------------------------------------------------------
    // Flag storage
    //--------------------------------------------------------------
    // One flop per line; a result only touches its own line
    for (genvar i = 0; i < NUM; i++) begin : g_line
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                flags_reg[i] <= 1'b0;
            end else if (det.valid && det.line == LINE_W'(i)) begin
                flags_reg[i] <= det.fault;
            end
        end
    end

    // New warning appears on a clean line
    assign rise = det.valid && det.fault && !flags_reg[det.line];

endmodule

// ==== lfr_irq.sv ====
//------------------------------------------------------------------
// Purpose: Sticky event status, mask and level interrupt
// Assumes: Clear strobe carries the written ones for one cycle
// Notes:   A set in the clearing cycle wins over the clear
//------------------------------------------------------------------
`timescale 1ns/1ps
module lfr_irq
    import lfr_pkg::*;
(
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Events and software access
    input  wire logic [IRQ_W-1:0] set,
    input  wire logic [IRQ_W-1:0] clr,
    input  wire logic             mask_we,
    input  wire logic [IRQ_W-1:0] mask_wdata,
    // State and interrupt
    output logic [IRQ_W-1:0]      status_reg,
    output logic [IRQ_W-1:0]      mask_reg,
    output logic                  irq
);

    logic [IRQ_W-1:0] status_next;

    // Set over clear so no event is lost
    assign status_next = (status_reg & ~clr) | set;

    // Status flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            status_reg <= IRQ_RESET;
        end else begin
            status_reg <= status_next;
        end
    end

    // Mask flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mask_reg <= IRQ_RESET;
        end else if (mask_we) begin
            mask_reg <= mask_wdata;
        end
    end

    // Level output, high while an enabled event is pending
    assign irq = |(status_reg & mask_reg);

endmodule

// ==== lfr_regs.sv ====
//------------------------------------------------------------------
// Purpose: LED fault line select and line warning register bank
// Assumes: Avalon-MM slave on clk, detection logic on the same clock
// Notes:   Every access waits one cycle; read data from a register
//------------------------------------------------------------------
// Overview of operation
// - Short line select: 6-bit read/write, bits 47..6 read zero
// - Open high-line flags: bits 15..0 are lines 48..63, rest zero
// - Open low-line flags: bit n reports line n, lines 0..47
// - Flag zero means no warning; all flags reset to zero
// - Open flags are read-only; bus writes never change them
// - Short flags use the same high and low line layout
// - Open line select: 6-bit read/write, same line encoding
//
// Design decisions made here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module lfr_regs
    import lfr_pkg::*;
(
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    // Avalon-MM slave
    input  wire logic [ADDR_W-1:0]     address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [BUS_W-1:0]      writedata,
    input  wire logic [3:0]            byteenable,
    output logic [BUS_W-1:0]           readdata,
    output logic                       waitrequest,
    // Detection results
    input  wire lfr_det_t              open_det,
    input  wire lfr_det_t              short_det,
    // Line selects toward detection
    output logic [LINE_W-1:0]          short_scan_line_select,
    output logic [LINE_W-1:0]          open_scan_line_select,
    // Interrupt
    output logic                       irq
);

    //--------------------------------------------------------------
    // Internal signals
    //--------------------------------------------------------------
    logic                  ack_reg;
    logic                  wr_en;
    logic [ADDR_W-1:0]     pair;
    logic                  upper;
    logic [REG_W-1:0]      rd_word;
    logic [BUS_W-1:0]      readdata_next;
    logic [LINE_W-1:0]     short_sel_reg;
    logic [LINE_W-1:0]     open_sel_reg;
    logic [NUM_LINES-1:0]  open_load_line_flags;
    logic [NUM_LINES-1:0]  short_line_flags;
    logic                  open_rise;
    logic                  short_rise;
    logic [IRQ_W-1:0]      irq_status;
    logic [IRQ_W-1:0]      irq_mask;
    logic [IRQ_W-1:0]      irq_clr;
    logic                  mask_we;

    //--------------------------------------------------------------
    // Bus handshake
    //--------------------------------------------------------------
    // One wait state gives the read mux a full cycle
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= (read || write) && !ack_reg;
        end
    end

    assign waitrequest = (read || write) && !ack_reg;
    assign wr_en       = write && ack_reg;
    assign pair        = {address[ADDR_W-1:PAIR_LSB], 3'h0};
    assign upper       = address[HALF_BIT];

    //--------------------------------------------------------------
    // Line select registers
    //--------------------------------------------------------------
    // short select write
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            short_sel_reg <= SEL_RESET;
        end else if (wr_en && pair == OFF_SHORT_SEL && !upper
                     && byteenable[0]) begin
            short_sel_reg <= writedata[LINE_W-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            open_sel_reg <= SEL_RESET;
        end else if (wr_en && pair == OFF_OPEN_SEL && !upper
                     && byteenable[0]) begin
            open_sel_reg <= writedata[LINE_W-1:0];
        end
    end

    assign short_scan_line_select = short_sel_reg;
    assign open_scan_line_select  = open_sel_reg;

    //--------------------------------------------------------------
    // Warning flag banks
    //--------------------------------------------------------------
    // reset clears, results update
    // banks see no bus write path, so writes cannot alter them
    lfr_flag_bank #(
        .NUM       (NUM_LINES)
    ) u_open_flags (
        .clk       (clk),
        .rst_n     (rst_n),
        .det       (open_det),
        .flags_reg (open_load_line_flags),
        .rise      (open_rise)
    );

    lfr_flag_bank #(
        .NUM       (NUM_LINES)
    ) u_short_flags (
        .clk       (clk),
        .rst_n     (rst_n),
        .det       (short_det),
        .flags_reg (short_line_flags),
        .rise      (short_rise)
    );

    //--------------------------------------------------------------
    // Interrupt status and mask
    //--------------------------------------------------------------
    // Write-one-to-clear status in the low word, mask in the high
    assign irq_clr = (wr_en && pair == OFF_IRQ && !upper
                      && byteenable[0]) ? writedata[IRQ_W-1:0]
                                        : IRQ_RESET;
    assign mask_we = wr_en && pair == OFF_IRQ && upper && byteenable[0];

    lfr_irq u_irq (
        .clk        (clk),
        .rst_n      (rst_n),
        .set        ({short_rise, open_rise}),
        .clr        (irq_clr),
        .mask_we    (mask_we),
        .mask_wdata (writedata[IRQ_W-1:0]),
        .status_reg (irq_status),
        .mask_reg   (irq_mask),
        .irq        (irq)
    );

    //--------------------------------------------------------------
    // Read mux
    //--------------------------------------------------------------
    // flags placed per line
    // Reserved bits come from the zero fill of each case
    always_comb begin
        rd_word = '0;
        case (pair)
            OFF_SHORT_SEL: begin
                rd_word[LINE_W-1:0] = short_sel_reg;
            end
            OFF_OPEN_SEL: begin
                rd_word[LINE_W-1:0] = open_sel_reg;
            end
            OFF_OPEN_HIGH: begin
                rd_word[HI_LINES-1:0] =
                    open_load_line_flags[NUM_LINES-1:LOW_LINES];
            end
            OFF_OPEN_LOW: begin
                rd_word = open_load_line_flags[LOW_LINES-1:0];
            end
            OFF_SHORT_HIGH: begin
                rd_word[HI_LINES-1:0] =
                    short_line_flags[NUM_LINES-1:LOW_LINES];
            end
            OFF_SHORT_LOW: begin
                rd_word = short_line_flags[LOW_LINES-1:0];
            end
            OFF_IRQ: begin
                rd_word[IRQ_W-1:0] = irq_status;
                rd_word[BUS_W+IRQ_W-1:BUS_W] = irq_mask;
            end
            default: begin
                rd_word = '0;
            end
        endcase
    end

    // Pick the half; upper word only has 16 live bits
    assign readdata_next = upper ? {16'h0000, rd_word[REG_W-1:BUS_W]}
                                 : rd_word[BUS_W-1:0];

    // Read data flop, loaded in the cycle that ends the wait
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            readdata <= '0;
        end else if (read && !ack_reg) begin
            readdata <= readdata_next;
        end
    end

    //--------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    // Every request is answered within two cycles
    a_bus_answer_bound:
    assert property ((read || write) |-> ##[0:1] !waitrequest)
        else $error("request not answered in time");

    a_short_sel_write:
    assert property (wr_en && pair == OFF_SHORT_SEL && !upper
                     && byteenable[0]
                     |=> short_scan_line_select
                         == $past(writedata[LINE_W-1:0]))
        else $error("short select not written");

    // short select reads show zeros above the field
    a_sel_reserved_zero:
    assert property (read && !ack_reg && pair == OFF_SHORT_SEL
                     |=> readdata[BUS_W-1:LINE_W] == '0
                         && readdata[LINE_W-1:0]
                            == ($past(upper) ? '0
                               : short_scan_line_select))
        else $error("select read wrong");

    a_open_sel_write:
    assert property (wr_en && pair == OFF_OPEN_SEL && !upper
                     && byteenable[0]
                     |=> open_scan_line_select
                         == $past(writedata[LINE_W-1:0]))
        else $error("open select not written");

    // high-line word maps lines 48..63 and zero above
    a_open_high_map:
    assert property (read && !ack_reg && pair == OFF_OPEN_HIGH
                     && !upper && !open_det.valid
                     |=> readdata == {16'h0000,
                         open_load_line_flags[NUM_LINES-1:LOW_LINES]})
        else $error("open high-line read wrong");

    // low-line word maps bit n to line n
    a_open_low_map:
    assert property (read && !ack_reg && pair == OFF_OPEN_LOW
                     && !upper && !open_det.valid
                     |=> readdata == open_load_line_flags[BUS_W-1:0])
        else $error("open low-line read wrong");

    // short low-line upper word holds lines 32..47
    a_short_low_upper:
    assert property (read && !ack_reg && pair == OFF_SHORT_LOW
                     && upper && !short_det.valid
                     |=> readdata == {16'h0000,
                         short_line_flags[LOW_LINES-1:BUS_W]})
        else $error("short low-line read wrong");

    // flags are clear right after reset
    a_flags_reset_zero:
    assert property ($rose(rst_n) |-> open_load_line_flags == '0
                                      && short_line_flags == '0)
        else $error("flags not cleared by reset");

    // bus writes leave the flags alone
    a_flags_read_only:
    assert property (wr_en && !open_det.valid && !short_det.valid
                     |=> $stable(open_load_line_flags)
                         && $stable(short_line_flags))
        else $error("write changed a flag");

    // a result lands on its own line
    a_det_updates_flag:
    assert property (open_det.valid
                     |=> open_load_line_flags[$past(open_det.line)]
                         == $past(open_det.fault))
        else $error("detection result not stored");

    // without a result the flags hold
    a_flags_hold:
    assert property (!open_det.valid && !short_det.valid
                     |=> $stable(open_load_line_flags)
                         && $stable(short_line_flags))
        else $error("flags changed without a result");

    // New warning raises the sticky bit even during a clear
    a_event_sticky:
    assert property (open_rise |=> irq_status[IRQ_OPEN])
        else $error("open event lost");

    // short high-line word maps lines 48..63
    a_short_high_map:
    assert property (read && !ack_reg && pair == OFF_SHORT_HIGH
                     && !upper && !short_det.valid
                     |=> readdata == {16'h0000,
                         short_line_flags[NUM_LINES-1:LOW_LINES]})
        else $error("short high-line read wrong");

    // open low-line upper word holds lines 32..47
    a_open_low_upper:
    assert property (read && !ack_reg && pair == OFF_OPEN_LOW
                     && upper && !open_det.valid
                     |=> readdata == {16'h0000,
                         open_load_line_flags[LOW_LINES-1:BUS_W]})
        else $error("open low-line upper read wrong");

    // reserved upper word of the high-line flags reads zero
    a_flag_reserved_zero:
    assert property (read && !ack_reg && pair == OFF_OPEN_HIGH && upper
                     |=> readdata == '0)
        else $error("reserved flag bits not zero");

    // a short result lands on its own line
    a_short_det_store:
    assert property (short_det.valid
                     |=> short_line_flags[$past(short_det.line)]
                         == $past(short_det.fault))
        else $error("short result not stored");

    // Writing a one clears status unless the event repeats
    a_status_clear:
    assert property (irq_clr[IRQ_OPEN] && !open_rise
                     |=> !irq_status[IRQ_OPEN])
        else $error("status bit not cleared");

    // Mask takes the written value
    a_mask_write:
    assert property (mask_we |=> irq_mask == $past(writedata[IRQ_W-1:0]))
        else $error("mask not written");

    // Unmasked event drives the interrupt pin
    a_irq_on_event:
    assert property (open_rise && irq_mask[IRQ_OPEN] && !mask_we |=> irq)
        else $error("interrupt not raised");

    // Main scenarios
    c_sel_write:
    cover property (wr_en && pair == OFF_SHORT_SEL);
    c_new_warning:
    cover property (short_rise ##1 irq);
    c_flag_read:
    cover property (open_rise ##[1:8] (read && pair == OFF_OPEN_LOW));
    c_set_and_clear:
    cover property (open_rise && irq_clr[IRQ_OPEN]);

endmodule

// ==== lfr_regs_tb.sv ====
//------------------------------------------------------------------
// Purpose: Self-checking bench for the LED line fault register bank
// Assumes: One wait state per access, detection on the same clock
// Notes:   Reference model keeps flags, selects, status and mask
//------------------------------------------------------------------
`timescale 1ns/1ps
module lfr_regs_tb
    import lfr_pkg::*;
;
    localparam logic [ADDR_W-1:0] OFF_MASK = OFF_IRQ + 6'h04;

    // Design signals
    logic              clk;
    logic              rst_n;
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [BUS_W-1:0]  writedata;
    logic [3:0]        byteenable;
    logic [BUS_W-1:0]  readdata;
    logic              waitrequest;
    lfr_det_t          open_det;
    lfr_det_t          short_det;
    logic [LINE_W-1:0] ssel;
    logic [LINE_W-1:0] osel;
    logic              irq;

    // Reference model and bookkeeping
    logic [63:0]       open_m;
    logic [63:0]       short_m;
    logic [5:0]        ssel_m;
    logic [5:0]        osel_m;
    logic [1:0]        stat_m;
    logic [1:0]        mask_m;
    int                mismatches;
    int                cmp_count;
    int                seed;
    logic [31:0]       rd;
    logic [5:0]        ln;
    logic [31:0]       wv;

    lfr_regs DUT (
        .clk                    (clk),
        .rst_n                  (rst_n),
        .address                (address),
        .read                   (read),
        .write                  (write),
        .writedata              (writedata),
        .byteenable             (byteenable),
        .readdata               (readdata),
        .waitrequest            (waitrequest),
        .open_det               (open_det),
        .short_det              (short_det),
        .short_scan_line_select (ssel),
        .open_scan_line_select  (osel),
        .irq                    (irq)
    );

    // 25 MHz clock
    always #20 clk = ~clk;

    //--------------------------------------------------------------
    // Tasks
    //--------------------------------------------------------------
    task automatic wrap_up;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One Avalon access; held until waitrequest is seen low at an edge
    task automatic bus(input logic we, input logic [5:0] a,
                       input logic [31:0] wd, output logic [31:0] d);
        int n;
        @(posedge clk);
        address   <= a;
        read      <= ~we;
        write     <= we;
        writedata <= wd;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (waitrequest !== 1'b0) begin
            mismatches++;
            wrap_up();
        end
        // Data and write both land at this edge; release only now
        d = readdata;
        read  <= 1'b0;
        write <= 1'b0;
        // Model follows only once the write edge has passed
        if (we) begin
            case (a)
                OFF_SHORT_SEL: ssel_m = wd[5:0];
                OFF_OPEN_SEL:  osel_m = wd[5:0];
                OFF_IRQ:       stat_m = stat_m & ~wd[1:0];
                OFF_MASK:      mask_m = wd[1:0];
                default:       ;
            endcase
        end
    endtask

    // One detection result; a 0 to 1 flag change raises status
    task automatic det(input logic shrt, input logic [5:0] l,
                       input logic f);
        @(posedge clk);
        if (shrt) short_det <= '{1'b1, l, f};
        else      open_det  <= '{1'b1, l, f};
        @(posedge clk);
        open_det  <= '0;
        short_det <= '0;
        if (shrt) begin
            if (f && !short_m[l]) stat_m[IRQ_SHORT] = 1'b1;
            short_m[l] = f;
        end else begin
            if (f && !open_m[l]) stat_m[IRQ_OPEN] = 1'b1;
            open_m[l] = f;
        end
    endtask

    function automatic logic [31:0] exp_word(input logic [5:0] a);
        case (a)
            OFF_SHORT_SEL:         return {26'h0, ssel_m};
            OFF_OPEN_SEL:          return {26'h0, osel_m};
            OFF_OPEN_HIGH:         return {16'h0, open_m[63:48]};
            OFF_OPEN_LOW:          return open_m[31:0];
            OFF_OPEN_LOW + 6'h04:  return {16'h0, open_m[47:32]};
            OFF_SHORT_HIGH:        return {16'h0, short_m[63:48]};
            OFF_SHORT_LOW:         return short_m[31:0];
            OFF_SHORT_LOW + 6'h04: return {16'h0, short_m[47:32]};
            OFF_IRQ:               return {30'h0, stat_m};
            OFF_MASK:              return {30'h0, mask_m};
            default:               return 32'h0;
        endcase
    endfunction

    // Reads every word, unmapped ones included, plus the irq pin
    task automatic check_all;
        logic [31:0] d;
        logic [31:0] e;
        for (int a = 0; a < 64; a += 4) begin
            bus(1'b0, a[5:0], 32'h0, d);
            e = exp_word(a[5:0]);
            check($sformatf("word_%0h", a), d, e);
        end
        @(negedge clk);
        check("irq", {31'h0, irq}, {31'h0, |(stat_m & mask_m)});
        check("short_sel", {26'h0, ssel}, {26'h0, ssel_m});
        check("open_sel", {26'h0, osel}, {26'h0, osel_m});
    endtask

    //--------------------------------------------------------------
    // Main sequence
    //--------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        address = '0;
        read = 1'b0;
        write = 1'b0;
        writedata = '0;
        byteenable = 4'hf;
        open_det = '0;
        short_det = '0;
        open_m = '0;
        short_m = '0;
        ssel_m = '0;
        osel_m = '0;
        stat_m = '0;
        mask_m = '0;
        mismatches = 0;
        cmp_count = 0;
        seed = 20;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        check_all;
        // select encodings, upper words read zero
        for (int i = 0; i < 4; i++) begin
            wv = (i == 3) ? $random(seed) : i * 32'h1f + i / 2;
            bus(1'b1, OFF_SHORT_SEL, wv, rd);
            bus(1'b1, OFF_OPEN_SEL, ~wv, rd);
            bus(1'b1, OFF_SHORT_SEL + 6'h04, 32'hffff_ffff, rd);
            bus(1'b1, OFF_OPEN_SEL + 6'h04, 32'hffff_ffff, rd);
            check_all;
        end
        for (int i = 0; i < 8; i++) begin
            ln = (i % 4 == 0) ? 6'h00 : (i % 4 == 1) ? 6'h2f :
                 (i % 4 == 2) ? 6'h30 : 6'h3f;
            det(i[2], ln, 1'b1);
        end
        check_all;
        bus(1'b1, OFF_MASK, 32'h0000_0003, rd);
        for (int i = 0; i < 60; i++) begin
            det($random(seed) & 1, $random(seed), $random(seed) & 1);
        end
        check_all;
        for (int a = 16; a < 48; a += 4) begin
            bus(1'b1, a[5:0], 32'hffff_ffff, rd);
        end
        check_all;
        // Sticky status: clear one bit, then both
        bus(1'b1, OFF_IRQ, 32'h0000_0001, rd);
        check_all;
        bus(1'b1, OFF_IRQ, 32'h0000_0003, rd);
        check_all;
        // results clear flags and hold until updated
        det(1'b0, 6'h30, 1'b0);
        det(1'b1, 6'h00, 1'b0);
        det(1'b0, 6'h30, 1'b1);
        check_all;
        // Masked event leaves irq low until unmasked
        bus(1'b1, OFF_IRQ, 32'h0000_0003, rd);
        bus(1'b1, OFF_MASK, 32'h0000_0002, rd);
        det(1'b0, 6'h30, 1'b0);
        det(1'b0, 6'h30, 1'b1);
        check_all;
        bus(1'b1, OFF_MASK, 32'h0000_0001, rd);
        check_all;
        wrap_up();
    end
endmodule
